// ==== pkg/ebz_defines.vh ====
// constants for the external bus zone interface
// assumes inclusion by bare name from hw/ design files
`ifndef EBZ_DEFINES_VH
`define EBZ_DEFINES_VH
`define EBZ_ADDR_W 19
`define EBZ_DATA_W 16
`define EBZ_ZONE_W 3
`define EBZ_TIM_W 3
`define EBZ_ZONE0 3'h0
`define EBZ_ZONE1 3'h1
`define EBZ_ZONE2 3'h2
`define EBZ_ZONE6 3'h6
`define EBZ_ZONE7 3'h7
`define EBZ_NZONES 8
`define EBZ_TIM_RST 3'h1
`define EBZ_BOOT_CYC 3'h5
`endif

// ==== hw/ebz_sync.v ====
// three-stage synchroniser with agreement filter for pin inputs
// assumes pin changes slower than two clock periods
`timescale 1ns/1ps
module ebz_sync #(
   parameter RST_VAL = 1'b1
) (
   input wire clk_in,
   input wire rstn_in,
   input wire d_in,
   output reg q_out
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q_out <= s3_reg;
         end
      end
   end
endmodule

// ==== hw/ebz_top.v ====
// external bus zone interface: zone selects, shaped strobes, hold
// assumes one access request at a time from the core, held until done
//
// How it works
// R1: mode high: zone 7 goes to external bus
// R2: mode low: zone 7 served by boot memory
// R3: mode pin latched at reset, software may change
// R4: hold request floats address, data, strobes
// R5: release only after access done, none pending
// R6: grant low while bus floats
// R7: grant rises when request released, resume
// R8: outside master drives bus only during grant
// R9: zone 0/1 select low during access
// R10: zone 2 select low during access
// R11: zone 6/7 select low during access
// R12: write strobe shaped by zone timing
// R13: read strobe shaped by zone timing
// R14: read and write strobes never together
// R15: read-not-write high except during writes
// R16: peripheral drives ready high to finish
// R17: ready sampled synchronous or asynchronous
// R18: 19-bit external address bus
// R19: 16-bit bidirectional data bus
// R20: phases counted in cycles, ready stretches active
// R21: selects and strobes high when idle
`timescale 1ns/1ps
`include "ebz_defines.vh"
module ebz_top #(
   parameter AW = `EBZ_ADDR_W,
   parameter DW = `EBZ_DATA_W,
   parameter TW = `EBZ_TIM_W
) (
   input wire CLK_IN,
   input wire RSTN_IN,
   input wire REQ_VALID_IN,
   output wire REQ_READY_OUT,
   input wire REQ_WRITE_IN,
   input wire [`EBZ_ZONE_W-1:0] REQ_ZONE_IN,
   input wire [AW-1:0] REQ_ADDR_IN,
   input wire [DW-1:0] REQ_WDATA_IN,
   output reg RSP_VALID_OUT,
   output reg [DW-1:0] RSP_RDATA_OUT,
   output reg BOOT_ACCESS_OUT,
   input wire [`EBZ_NZONES*TW-1:0] LEAD_CFG_IN,
   input wire [`EBZ_NZONES*TW-1:0] ACTIVE_CFG_IN,
   input wire [`EBZ_NZONES*TW-1:0] TRAIL_CFG_IN,
   input wire [`EBZ_NZONES-1:0] READY_EN_IN,
   input wire READY_ASYNC_IN,
   input wire MODE_WR_IN,
   input wire MODE_WDATA_IN,
   output reg MODE_BIT_OUT,
   input wire BOOT_MODE_SELECT_PIN_IN,
   input wire BUS_HOLD_REQUEST_N_IN,
   output reg BUS_HOLD_GRANT_N_OUT,
   output wire BUS_HOLD_GRANT_N_OE_OUT,
   input wire TARGET_READY_IN,
   output reg [AW-1:0] EXT_ADDRESS_OUT,
   output wire EXT_ADDRESS_OE_OUT,
   input wire [DW-1:0] EXT_DATA_IN,
   output reg [DW-1:0] EXT_DATA_OUT,
   output reg EXT_DATA_OE_OUT,
   output reg ZONE01_SELECT_N_OUT,
   output reg ZONE2_SELECT_N_OUT,
   output reg ZONE67_SELECT_N_OUT,
   output reg WRITE_STROBE_N_OUT,
   output reg READ_STROBE_N_OUT,
   output reg READ_NOT_WRITE_OUT,
   output wire CTRL_OE_OUT
);
   localparam ST_IDLE = 3'h0;
   localparam ST_LEAD = 3'h1;
   localparam ST_ACT = 3'h2;
   localparam ST_TRAIL = 3'h3;
   localparam ST_HOLD = 3'h4;

   // picks one zone's field from a packed timing vector
   function [TW-1:0] zfield;
      input [`EBZ_NZONES*TW-1:0] v;
      input [`EBZ_ZONE_W-1:0] z;
      begin
         zfield = v[z*TW +: TW];
      end
   endfunction

   // =========================================================
   // pin synchronisers
   // =========================================================
   wire hold_req_n_s;
   wire ready_async_s;
   wire mode_pin_s;
   reg ready_sync_reg;
   ebz_sync #(.RST_VAL(1'b1)) u_hold (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .d_in(BUS_HOLD_REQUEST_N_IN),
      .q_out(hold_req_n_s)
   );
   ebz_sync #(.RST_VAL(1'b0)) u_rdy (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .d_in(TARGET_READY_IN),
      .q_out(ready_async_s)
   );
   ebz_sync #(.RST_VAL(1'b0)) u_mode (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .d_in(BOOT_MODE_SELECT_PIN_IN),
      .q_out(mode_pin_s)
   );
   // synchronous ready: single register, timing met by the target
   always @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         ready_sync_reg <= 1'b0;
      end else begin
         ready_sync_reg <= TARGET_READY_IN;
      end
   end
   wire ready_s = READY_ASYNC_IN ? ready_async_s : ready_sync_reg; // [R17]

   // =========================================================
   // mode bit: pin followed while reset recently released
   // =========================================================
   reg [2:0] boot_cnt_reg;
   always @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         boot_cnt_reg <= 3'h0;
         MODE_BIT_OUT <= 1'b0;
      end else if (boot_cnt_reg != `EBZ_BOOT_CYC) begin
         // pin needs four edges to cross the synchroniser
         boot_cnt_reg <= boot_cnt_reg + 3'h1;
         MODE_BIT_OUT <= mode_pin_s; // [R3]
      end else if (MODE_WR_IN) begin
         MODE_BIT_OUT <= MODE_WDATA_IN; // [R3]
      end
   end
   wire boot_done = (boot_cnt_reg == `EBZ_BOOT_CYC);

   // =========================================================
   // access sequencer
   // =========================================================
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [TW-1:0] cnt_reg;
   reg [TW-1:0] cnt_next;
   reg [`EBZ_ZONE_W-1:0] zone_reg;
   reg wr_reg;
   reg boot_z7;

   always @* begin
      boot_z7 = (REQ_ZONE_IN == `EBZ_ZONE7) && !MODE_BIT_OUT; // [R2]
   end
   // boot memory answers inside the core; not accepted here
   assign REQ_READY_OUT = (state_reg == ST_IDLE) && boot_done &&
                          hold_req_n_s && !boot_z7; // [R5]

   wire ready_ok = !READY_EN_IN[zone_reg] || ready_s; // [R20]

   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         ST_IDLE: begin
            if (!hold_req_n_s) begin
               state_next = ST_HOLD; // [R4] [R5]
            end else if (REQ_VALID_IN && REQ_READY_OUT) begin
               state_next = ST_LEAD;
               cnt_next = zfield(LEAD_CFG_IN, REQ_ZONE_IN);
            end
         end
         ST_LEAD: begin
            if (cnt_reg > `EBZ_TIM_RST) begin
               cnt_next = cnt_reg - `EBZ_TIM_RST;
            end else begin
               state_next = ST_ACT;
               cnt_next = zfield(ACTIVE_CFG_IN, zone_reg);
            end
         end
         ST_ACT: begin
            if (cnt_reg > `EBZ_TIM_RST) begin
               cnt_next = cnt_reg - `EBZ_TIM_RST;
            end else if (ready_ok) begin // [R20]
               state_next = ST_TRAIL;
               cnt_next = zfield(TRAIL_CFG_IN, zone_reg);
            end
         end
         ST_TRAIL: begin
            if (cnt_reg > `EBZ_TIM_RST) begin
               cnt_next = cnt_reg - `EBZ_TIM_RST;
            end else begin
               state_next = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (hold_req_n_s) begin
               state_next = ST_IDLE; // [R7]
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   wire start = (state_reg == ST_IDLE) && (state_next == ST_LEAD);
   wire in_acc = (state_next == ST_LEAD) || (state_next == ST_ACT) ||
                 (state_next == ST_TRAIL);
   wire strobe_on = (state_next == ST_ACT);
   wire [`EBZ_ZONE_W-1:0] zone_n = start ? REQ_ZONE_IN : zone_reg;
   wire wr_n = start ? REQ_WRITE_IN : wr_reg;

   always @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         state_reg <= ST_IDLE;
         cnt_reg <= {TW{1'b0}};
         zone_reg <= `EBZ_ZONE0;
         wr_reg <= 1'b0;
         EXT_ADDRESS_OUT <= {AW{1'b0}};
         EXT_DATA_OUT <= {DW{1'b0}};
         EXT_DATA_OE_OUT <= 1'b0;
         ZONE01_SELECT_N_OUT <= 1'b1;
         ZONE2_SELECT_N_OUT <= 1'b1;
         ZONE67_SELECT_N_OUT <= 1'b1;
         WRITE_STROBE_N_OUT <= 1'b1;
         READ_STROBE_N_OUT <= 1'b1;
         READ_NOT_WRITE_OUT <= 1'b1;
         BUS_HOLD_GRANT_N_OUT <= 1'b1;
         RSP_VALID_OUT <= 1'b0;
         RSP_RDATA_OUT <= {DW{1'b0}};
         BOOT_ACCESS_OUT <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         zone_reg <= zone_n;
         wr_reg <= wr_n;
         if (start) begin
            EXT_ADDRESS_OUT <= REQ_ADDR_IN; // [R18]
            EXT_DATA_OUT <= REQ_WDATA_IN;
         end
         EXT_DATA_OE_OUT <= in_acc && wr_n; // [R19]
         ZONE01_SELECT_N_OUT <= !(in_acc && (zone_n == `EBZ_ZONE0 ||
                                  zone_n == `EBZ_ZONE1)); // [R9] [R21]
         ZONE2_SELECT_N_OUT <= !(in_acc &&
                                 zone_n == `EBZ_ZONE2); // [R10] [R21]
         ZONE67_SELECT_N_OUT <= !(in_acc && (zone_n == `EBZ_ZONE6 ||
                                  zone_n == `EBZ_ZONE7)); // [R11] [R1]
         WRITE_STROBE_N_OUT <= !(strobe_on && wr_n); // [R12] [R14]
         READ_STROBE_N_OUT <= !(strobe_on && !wr_n); // [R13] [R14]
         READ_NOT_WRITE_OUT <= !(in_acc && wr_n); // [R15]
         BUS_HOLD_GRANT_N_OUT <= !(state_next == ST_HOLD); // [R6] [R7]
         RSP_VALID_OUT <= (state_reg == ST_TRAIL) &&
                          (state_next == ST_IDLE);
         if ((state_reg == ST_ACT) && (state_next == ST_TRAIL) &&
             !wr_reg) begin
            RSP_RDATA_OUT <= EXT_DATA_IN; // [R19]
         end
         BOOT_ACCESS_OUT <= REQ_VALID_IN && boot_z7 && boot_done; // [R2]
      end
   end

   // floating while granted; outside master owns the bus then
   assign EXT_ADDRESS_OE_OUT = BUS_HOLD_GRANT_N_OUT; // [R4] [R8]
   assign CTRL_OE_OUT = BUS_HOLD_GRANT_N_OUT; // [R4]
   assign BUS_HOLD_GRANT_N_OE_OUT = 1'b1;
endmodule

// ==== bench/ebz_chk_assertions.sv ====
// checker for the zone bus: strobes, selects, hold handshake
// assumes binding onto ebz_top, one clock domain
`timescale 1ns/1ps
module ebz_chk (
   input wire CLK_IN,
   input wire RSTN_IN,
   input wire REQ_VALID_IN,
   input wire REQ_READY_OUT,
   input wire [2:0] REQ_ZONE_IN,
   input wire MODE_BIT_OUT,
   input wire BUS_HOLD_REQUEST_N_IN,
   input wire BUS_HOLD_GRANT_N_OUT,
   input wire EXT_ADDRESS_OE_OUT,
   input wire EXT_DATA_OE_OUT,
   input wire CTRL_OE_OUT,
   input wire ZONE01_SELECT_N_OUT,
   input wire ZONE2_SELECT_N_OUT,
   input wire ZONE67_SELECT_N_OUT,
   input wire WRITE_STROBE_N_OUT,
   input wire READ_STROBE_N_OUT,
   input wire READ_NOT_WRITE_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   wire idle_w = ZONE01_SELECT_N_OUT & ZONE2_SELECT_N_OUT &
      ZONE67_SELECT_N_OUT & WRITE_STROBE_N_OUT & READ_STROBE_N_OUT &
      READ_NOT_WRITE_OUT;
   wire take_w = REQ_VALID_IN & REQ_READY_OUT;
   // ==========
   // strobes, selects, idle lines, boot zone
   property p_mutex; WRITE_STROBE_N_OUT | READ_STROBE_N_OUT; endproperty
   a_mutex: assert property (p_mutex) else $error("both strobes");
   property p_rnw; !(WRITE_STROBE_N_OUT & READ_STROBE_N_OUT) |->
      READ_NOT_WRITE_OUT == WRITE_STROBE_N_OUT; endproperty
   a_rnw: assert property (p_rnw) else $error("rnw wrong");
   property p_idle; REQ_READY_OUT |-> idle_w; endproperty
   a_idle: assert property (p_idle) else $error("busy lines");
   property p_z01; take_w && REQ_ZONE_IN[2:1] == 2'h0 |=>
      !ZONE01_SELECT_N_OUT && ZONE67_SELECT_N_OUT; endproperty
   a_z01: assert property (p_z01) else $error("zone01 sel");
   property p_z2; take_w && REQ_ZONE_IN == 3'h2 |=>
      !ZONE2_SELECT_N_OUT && ZONE01_SELECT_N_OUT; endproperty
   a_z2: assert property (p_z2) else $error("zone2 sel");
   property p_z67; take_w && REQ_ZONE_IN[2:1] == 2'h3 |=>
      !ZONE67_SELECT_N_OUT && ZONE2_SELECT_N_OUT; endproperty
   a_z67: assert property (p_z67) else $error("zone67 sel");
   property p_boot; REQ_VALID_IN && REQ_ZONE_IN == 3'h7 && !MODE_BIT_OUT
      |-> !REQ_READY_OUT; endproperty
   a_boot: assert property (p_boot) else $error("boot zone taken");
   // ==========
   // hold handshake
   property p_float; !BUS_HOLD_GRANT_N_OUT |->
      !(EXT_ADDRESS_OE_OUT | EXT_DATA_OE_OUT | CTRL_OE_OUT); endproperty
   a_float: assert property (p_float) else $error("driving in hold");
   property p_drain; $fell(BUS_HOLD_GRANT_N_OUT) |-> $past(idle_w);
   endproperty
   a_drain: assert property (p_drain) else $error("grant mid access");
   property p_free; $rose(BUS_HOLD_REQUEST_N_IN) |->
      ##[1:8] BUS_HOLD_GRANT_N_OUT; endproperty
   a_free: assert property (p_free) else $error("grant stuck");
endmodule
bind ebz_top ebz_chk u_chk (.*);

// ==== bench/ebz_target_model.sv ====
// memory target on the zone bus, with programmable wait states
// assumes active low strobes, data lines pulled up when released
`timescale 1ns/1ps
module ebz_target_model (
   input wire clk_in,
   input wire [18:0] addr_in,
   input wire [15:0] data_in,
   input wire data_oe_in,
   input wire rd_n_in,
   input wire wr_n_in,
   input wire [3:0] wait_in,
   output wire [15:0] data_out,
   output wire ready_out
);
   logic [15:0] mem_reg [16];
   logic [3:0] cnt_reg = 4'h0;
   always @(posedge clk_in) begin
      if (!wr_n_in) mem_reg[addr_in[3:0]] <= data_in;
      if (rd_n_in && wr_n_in) cnt_reg <= 4'h0;
      else if (cnt_reg != 4'hf) cnt_reg <= cnt_reg + 4'h1;
   end
   assign ready_out = cnt_reg >= wait_in;
   assign data_out = data_oe_in ? data_in :
      (!rd_n_in ? mem_reg[addr_in[3:0]] : 16'hffff);
endmodule

// ==== bench/tb_ebz_top.sv ====
// self-checking bench for the zone bus block
// assumes the target model on the far side of the bus
`timescale 1ns/1ps
module tb_ebz_top;
   logic clk = 1'b0, rstn = 1'b0, v = 1'b0, w = 1'b0, pin = 1'b1;
   logic hold_n = 1'b1, asy = 1'b0, mwr = 1'b0, mwd = 1'b0;
   logic [2:0] zn = 3'h0;
   logic [18:0] ad = 19'h0;
   logic [15:0] wd = 16'h0, q;
   logic [23:0] lead = {8{3'h1}}, act = {8{3'h1}};
   logic [7:0] ren = 8'h00;
   logic [3:0] wt = 4'h0;
   wire rdy, rsp, boot, mode, gnt_n, aoe, doe, rd_n, wr_n, trdy;
   wire [15:0] rdata, dout, din;
   wire [18:0] xa;
   int miscompares = 0, checked = 0, cyc = 0, n;
   ebz_top dut (.CLK_IN(clk), .RSTN_IN(rstn), .REQ_VALID_IN(v),
      .REQ_READY_OUT(rdy), .REQ_WRITE_IN(w), .REQ_ZONE_IN(zn),
      .REQ_ADDR_IN(ad), .REQ_WDATA_IN(wd), .RSP_VALID_OUT(rsp),
      .RSP_RDATA_OUT(rdata), .BOOT_ACCESS_OUT(boot), .LEAD_CFG_IN(lead),
      .ACTIVE_CFG_IN(act), .TRAIL_CFG_IN(lead), .READY_EN_IN(ren),
      .READY_ASYNC_IN(asy), .MODE_WR_IN(mwr), .MODE_WDATA_IN(mwd),
      .MODE_BIT_OUT(mode), .BOOT_MODE_SELECT_PIN_IN(pin),
      .BUS_HOLD_REQUEST_N_IN(hold_n), .BUS_HOLD_GRANT_N_OUT(gnt_n),
      .BUS_HOLD_GRANT_N_OE_OUT(), .TARGET_READY_IN(trdy),
      .EXT_ADDRESS_OUT(xa), .EXT_ADDRESS_OE_OUT(aoe), .EXT_DATA_IN(din),
      .EXT_DATA_OUT(dout), .EXT_DATA_OE_OUT(doe),
      .ZONE01_SELECT_N_OUT(), .ZONE2_SELECT_N_OUT(),
      .ZONE67_SELECT_N_OUT(), .WRITE_STROBE_N_OUT(wr_n),
      .READ_STROBE_N_OUT(rd_n), .READ_NOT_WRITE_OUT(), .CTRL_OE_OUT());
   ebz_target_model mdl (.clk_in(clk), .addr_in(xa), .data_in(dout),
      .data_oe_in(doe), .rd_n_in(rd_n), .wr_n_in(wr_n), .wait_in(wt),
      .data_out(din), .ready_out(trdy));
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         final_report;
      end
   end
   // ==========
   // access and compare tasks
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t data %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk({15'h0, g}, {15'h0, e});
   endtask
   // n returns cycles from take to response
   task automatic acc(input logic iw, input logic [2:0] iz,
      input logic [15:0] id);
      @(posedge clk);
      v <= 1'b1; w <= iw; zn <= iz; ad <= {16'h0, iz}; wd <= id;
      @(negedge clk);
      for (n = 0; n < 200 && !rdy; n++) @(negedge clk);
      @(posedge clk);
      v <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!rsp && n < 200);
      q = rdata;
   endtask
   task automatic final_report;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========
   // tests
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (12) @(posedge clk);
      pin <= 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk1(mode, 1'b1);
      $display("mode latch test done");
      for (int i = 0; i < 8; i++) acc(1'b1, i[2:0], 16'ha5a0 ^ 16'(i));
      for (int i = 0; i < 8; i++) begin
         acc(1'b0, i[2:0], 16'h0);
         chk(q, 16'ha5a0 ^ 16'(i));
      end
      $display("zone access test done");
      @(posedge clk);
      lead <= {{7{3'h1}}, 3'h2};
      act <= {{7{3'h1}}, 3'h3};
      acc(1'b0, 3'h0, 16'h0);
      chk(16'(n), 16'h8);
      @(posedge clk);
      ren <= 8'hff;
      wt <= 4'h3;
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         asy <= s[0];
         acc(1'b0, 3'h2, 16'h0);
         chk(q, 16'ha5a2);
         chk1(n > 4, 1'b1);
      end
      $display("timing and ready test done");
      @(posedge clk);
      mwr <= 1'b1;
      @(posedge clk);
      mwr <= 1'b0; v <= 1'b1; zn <= 3'h7;
      @(posedge clk);
      @(negedge clk);
      chk1(mode, 1'b0);
      chk1(boot, 1'b1);
      chk1(rdy, 1'b0);
      @(posedge clk);
      v <= 1'b0;
      $display("boot zone test done");
      fork
         acc(1'b1, 3'h6, 16'h1234);
         begin
            repeat (2) @(posedge clk);
            hold_n <= 1'b0;
         end
      join
      for (n = 0; n < 20 && gnt_n; n++) @(negedge clk);
      chk1(gnt_n, 1'b0);
      chk1(aoe, 1'b0);
      chk1(rdy, 1'b0);
      @(posedge clk);
      hold_n <= 1'b1;
      for (n = 0; n < 20 && !gnt_n; n++) @(negedge clk);
      chk1(gnt_n, 1'b1);
      acc(1'b0, 3'h6, 16'h0);
      chk(q, 16'h1234);
      $display("hold test done");
      final_report;
   end
endmodule
